// >>> rtl/ttpe_consts.svh
// Register offsets, field positions, reset values and counts of the transmit test path
`ifndef TTPE_CONSTS_SVH
`define TTPE_CONSTS_SVH
`define TTPE_ADDR_FRAME_FMT 9'h070
`define TTPE_ADDR_LINE_CODE 9'h071
`define TTPE_ADDR_ERR_INS 9'h073
`define TTPE_ADDR_PATT_CFG 9'h076
`define TTPE_ADDR_LOOP_CFG 9'h077
`define TTPE_ADDR_LOOP_PAT 9'h078
`define TTPE_ADDR_CHAN_BASE 9'h100
`define TTPE_ADDR_CHAN_LAST 9'h11F
`define TTPE_REG_RESET 8'h00
`define TTPE_FMT_CAS_BIT 3
`define TTPE_FMT_E1_BIT 7
`define TTPE_ERR_CV 0
`define TTPE_ERR_FRAME 1
`define TTPE_ERR_CRC 2
`define TTPE_ERR_ALIGN 3
`define TTPE_ERR_SLIP_DIR 4
`define TTPE_ERR_PRBS 5
`define TTPE_ERR_MF 6
`define TTPE_ERR_CAS_MF 7
`define TTPE_PATT_ZLIM_BIT 2
`define TTPE_PATT_FRAMED_BIT 3
`define TTPE_PATT_GO_BIT 4
`define TTPE_LOOP_UNFRAMED_BIT 2
`define TTPE_LOOP_GO_BIT 3
`define TTPE_LOOP_LEN_MIN 3'h4
`define TTPE_CHAN_B7_BIT 0
`define TTPE_LC_AMI 2'h0
`define TTPE_LC_ZCS 2'h1
`define TTPE_LC_PDV 2'h2
`define TTPE_LC_UMC 2'h3
`define TTPE_UMC_BYTE 8'h98
`define TTPE_B7_MASK 8'h02
`define TTPE_PDV_ZERO_MAX 4'hE
`define TTPE_ZLIM_SHORT 4'h7
`define TTPE_ZLIM_LONG 4'hE
`define TTPE_HDB3_RUN 3'h3
`define TTPE_B8ZS_RUN 3'h7
`define TTPE_PRBS_SEED 23'h7F_FFFF
`endif

// >>> rtl/ttpe_pkg.sv
// Shared types of the transmit test path
package ttpe_pkg;
  typedef enum logic [1:0] {
    TTPE_BIP_AMI = 2'b00,
    TTPE_BIP_HDB3 = 2'b01,
    TTPE_BIP_B8ZS = 2'b10
  } ttpe_bip_t;
  typedef enum logic [1:0] {
    TTPE_SYM_ZERO = 2'b00,
    TTPE_SYM_MARK = 2'b01,
    TTPE_SYM_VIOL = 2'b10
  } ttpe_sym_t;
endpackage : ttpe_pkg

// >>> rtl/ttpe_prbs.sv
// Selectable pseudo-random generator with optional zero-run cap
`timescale 1ns/1ps
`include "ttpe_consts.svh"
module ttpe_prbs (
  input wire logic clk,
  input wire logic rst,
  input wire logic adv,
  input wire logic [1:0] sel,
  input wire logic zlim,
  output logic bit_out
);
  logic [22:0] lfsr_reg;
  logic [3:0] zero_cnt_reg;
  logic raw;
  logic fb;
  logic [3:0] cap;

  always_comb
  begin
    case (sel)
      2'd0:
      begin
        raw = lfsr_reg[10];
        fb = lfsr_reg[10] ^ lfsr_reg[8];
      end
      2'd1:
      begin
        raw = lfsr_reg[14];
        fb = lfsr_reg[14] ^ lfsr_reg[13];
      end
      2'd2:
      begin
        raw = lfsr_reg[19];
        fb = lfsr_reg[19] ^ lfsr_reg[2];
      end
      default:
      begin
        raw = lfsr_reg[22];
        fb = lfsr_reg[22] ^ lfsr_reg[17];
      end
    endcase
    cap = sel[1] ? `TTPE_ZLIM_LONG : `TTPE_ZLIM_SHORT;
    bit_out = (zlim && zero_cnt_reg == cap) ? 1'b1 : raw;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lfsr_reg <= `TTPE_PRBS_SEED;
    else if (adv)
      lfsr_reg <= {lfsr_reg[21:0], fb};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      zero_cnt_reg <= 4'h0;
    else if (adv)
      zero_cnt_reg <= bit_out ? 4'h0 : zero_cnt_reg + 4'h1;
  end
endmodule : ttpe_prbs

// >>> rtl/ttpe_bipolar_enc.sv
// Dual-rail encoder: AMI, HDB3 and B8ZS substitution with violation injection
`timescale 1ns/1ps
`include "ttpe_consts.svh"
module ttpe_bipolar_enc (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire ttpe_pkg::ttpe_bip_t mode,
  input wire logic cv_req,
  output logic cv_done,
  output logic pos_out,
  output logic neg_out,
  output logic out_valid
);
  // Eight-symbol lookahead so a zero run can be rewritten before it leaves
  ttpe_pkg::ttpe_sym_t sym_reg [0:7];
  ttpe_pkg::ttpe_sym_t sym_next [0:7];
  logic [2:0] zrun_reg;
  logic par_reg;
  logic last_pol_reg;
  logic prev_mark_reg;
  logic [1:0] cv_cnt_reg;
  logic head_mark;
  logic inject;
  logic pol;

  always_comb
  begin
    for (int i = 7; i > 0; i--)
      sym_next[i] = sym_reg[i-1];
    sym_next[0] = bit_in ? ttpe_pkg::TTPE_SYM_MARK : ttpe_pkg::TTPE_SYM_ZERO;
    if (!bit_in && mode == ttpe_pkg::TTPE_BIP_HDB3 && zrun_reg == `TTPE_HDB3_RUN)
    begin
      sym_next[0] = ttpe_pkg::TTPE_SYM_VIOL;
      if (!par_reg)
        sym_next[3] = ttpe_pkg::TTPE_SYM_MARK;
    end
    if (!bit_in && mode == ttpe_pkg::TTPE_BIP_B8ZS && zrun_reg == `TTPE_B8ZS_RUN)
    begin
      sym_next[4] = ttpe_pkg::TTPE_SYM_VIOL;
      sym_next[3] = ttpe_pkg::TTPE_SYM_MARK;
      sym_next[1] = ttpe_pkg::TTPE_SYM_VIOL;
      sym_next[0] = ttpe_pkg::TTPE_SYM_MARK;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
        sym_reg[i] <= ttpe_pkg::TTPE_SYM_ZERO;
    end
    else if (bit_valid)
    begin
      for (int i = 0; i < 8; i++)
        sym_reg[i] <= sym_next[i];
    end
  end

  // Run length and mark parity since the last substitution
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      zrun_reg <= 3'h0;
      par_reg <= 1'b0;
    end
    else if (bit_valid)
    begin
      if (bit_in)
      begin
        zrun_reg <= 3'h0;
        par_reg <= ~par_reg;
      end
      else if (sym_next[0] != ttpe_pkg::TTPE_SYM_ZERO)
      begin
        zrun_reg <= 3'h0;
        par_reg <= 1'b0;
      end
      else
        zrun_reg <= zrun_reg + 3'h1;
    end
  end

  assign head_mark = sym_reg[7] != ttpe_pkg::TTPE_SYM_ZERO;
  assign inject = cv_cnt_reg != 2'h0 && sym_reg[7] == ttpe_pkg::TTPE_SYM_MARK
    && prev_mark_reg;
  // Violations reuse the last polarity; normal marks alternate
  assign pol = (sym_reg[7] == ttpe_pkg::TTPE_SYM_VIOL || inject) ? last_pol_reg
    : ~last_pol_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_pol_reg <= 1'b0;
      prev_mark_reg <= 1'b0;
      pos_out <= 1'b0;
      neg_out <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= bit_valid;
      if (bit_valid)
      begin
        prev_mark_reg <= head_mark;
        pos_out <= head_mark && pol;
        neg_out <= head_mark && !pol;
        if (head_mark)
          last_pol_reg <= pol;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cv_cnt_reg <= 2'h0;
      cv_done <= 1'b0;
    end
    else
    begin
      cv_done <= 1'b0;
      if (cv_cnt_reg == 2'h0 && cv_req && !cv_done)
        cv_cnt_reg <= (mode == ttpe_pkg::TTPE_BIP_HDB3) ? 2'h2 : 2'h1;
      else if (bit_valid && inject)
      begin
        cv_cnt_reg <= cv_cnt_reg - 2'h1;
        cv_done <= cv_cnt_reg == 2'h1;
      end
    end
  end
endmodule : ttpe_bipolar_enc

// >>> rtl/ttpe_tx_path.sv
// Transmit test pattern, error insertion, loop code and line coding path
`timescale 1ns/1ps
`include "ttpe_consts.svh"
// Overview of operation
// - Four PRBS lengths 2^11,15,20,23 minus one, two-bit select, overwrite when started.
// - Zero cap stops runs of 8 (short) or 15 (long) zeros.
// - T1 framed pattern skips the framing bit every 193 bits.
// - E1 framed pattern skips timeslot 0, and 16 under CAS; generator pauses.
// - Unframed pattern fills every bit including framing and signalling.
// - Each error bit written one injects once, zero does nothing; slip direction bit is held as written.
// - T1 violation request sends one bipolar violation, then clears itself.
// - E1 HDB3 violation request sends two same-polarity violations.
// - Frame-bit error inverts the next frame bit.
// - CRC error inverts the next CRC bit.
// - Alignment request shifts framing one bit; E1 picks direction, T1 deletes.
// - Pattern error inverts the next generator output bit.
// - Multiframe error inverts the next multiframe bit.
// - CAS multiframe error inverts the first alignment pattern bit.
// - Loop code repeats the loaded pattern with period 4 to 7.
// - Loop code only in T1; keeps framing bits unless unframed.
// - Byte substitution happens before the CRC feed output.
// - HDB3 uses 000V or B00V so violations alternate polarity.
// - B8ZS replaces eight zeros with 000VB0VB.
// - Enabled channels with an all-zero byte get bit 7 forced to one, except in idle-channel mode.
// - Density enforcer fills long zero runs, never framing bits, T1 only.
// - Idle-channel mode replaces zero bytes with 10011000.
module ttpe_tx_path (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire logic frame_bit_pos,
  input wire logic crc_bit_pos,
  input wire logic mf_bit_pos,
  input wire logic mas_first_pos,
  input wire logic [4:0] ts_num,
  input wire logic [2:0] bit_num,
  output logic subst_valid,
  output logic subst_bit,
  output logic pos_rail_out,
  output logic neg_rail_out,
  output logic rail_valid,
  output logic align_shift_pulse,
  output logic slip_direction_out
);
  logic [7:0] tx_frame_format_cfg_reg;
  logic [7:0] tx_line_code_cfg_reg;
  logic [7:0] error_insert_reg;
  logic [7:0] pattern_cfg_reg;
  logic [7:0] loop_code_cfg_reg;
  logic [7:0] loop_code_pattern_reg;
  logic [7:0] chan_ctrl_mem [0:31];
  logic [7:0] rdata_next;

  logic e1_mode;
  logic cas_mode;
  logic pattern_go;
  logic loop_code_go;
  logic [1:0] line_code_select;
  logic protected_bit;
  logic prbs_use;
  logic loop_use;
  logic prbs_bit;
  logic err_wr;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic cv_done;

  logic a_valid_reg;
  logic a_bit_reg;
  logic a_frame_reg;
  logic [4:0] a_ts_reg;
  logic [2:0] a_bitn_reg;
  logic a_bit_next;
  logic [2:0] loop_idx_reg;
  logic [2:0] loop_len;

  logic [7:0] byte_sr_reg;
  logic [7:0] frame_sr_reg;
  logic [7:0] byte_in;
  logic [7:0] byte_next;
  logic byte_end;
  logic [3:0] pdv_zero_reg;
  logic c_bit;
  ttpe_pkg::ttpe_bip_t bip_mode;

  assign e1_mode = tx_frame_format_cfg_reg[`TTPE_FMT_E1_BIT];
  assign cas_mode = tx_frame_format_cfg_reg[`TTPE_FMT_CAS_BIT];
  assign pattern_go = pattern_cfg_reg[`TTPE_PATT_GO_BIT];
  assign loop_code_go = loop_code_cfg_reg[`TTPE_LOOP_GO_BIT];
  assign line_code_select = tx_line_code_cfg_reg[1:0];
  assign err_wr = reg_wr && reg_addr == `TTPE_ADDR_ERR_INS;
  assign err_set = err_wr ? reg_wdata : 8'h00;

  // Register writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_frame_format_cfg_reg <= `TTPE_REG_RESET;
      tx_line_code_cfg_reg <= `TTPE_REG_RESET;
      pattern_cfg_reg <= `TTPE_REG_RESET;
      loop_code_cfg_reg <= `TTPE_REG_RESET;
      loop_code_pattern_reg <= `TTPE_REG_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TTPE_ADDR_FRAME_FMT)
        tx_frame_format_cfg_reg <= reg_wdata;
      else if (reg_addr == `TTPE_ADDR_LINE_CODE)
        tx_line_code_cfg_reg <= reg_wdata;
      else if (reg_addr == `TTPE_ADDR_PATT_CFG)
        pattern_cfg_reg <= reg_wdata;
      else if (reg_addr == `TTPE_ADDR_LOOP_CFG)
        loop_code_cfg_reg <= reg_wdata;
      else if (reg_addr == `TTPE_ADDR_LOOP_PAT)
        loop_code_pattern_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
        chan_ctrl_mem[i] <= `TTPE_REG_RESET;
    end
    else if (reg_wr && reg_addr >= `TTPE_ADDR_CHAN_BASE && reg_addr <= `TTPE_ADDR_CHAN_LAST)
      chan_ctrl_mem[reg_addr[4:0]] <= reg_wdata;
  end

  // Pending requests: a new write wins over consumption in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      error_insert_reg <= `TTPE_REG_RESET;
    else
    begin
      error_insert_reg <= (error_insert_reg & ~err_clr) | err_set;
      if (err_wr)
        error_insert_reg[`TTPE_ERR_SLIP_DIR] <= reg_wdata[`TTPE_ERR_SLIP_DIR];
    end
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_addr == `TTPE_ADDR_FRAME_FMT)
      rdata_next = tx_frame_format_cfg_reg;
    else if (reg_addr == `TTPE_ADDR_LINE_CODE)
      rdata_next = tx_line_code_cfg_reg;
    else if (reg_addr == `TTPE_ADDR_ERR_INS)
      rdata_next = error_insert_reg;
    else if (reg_addr == `TTPE_ADDR_PATT_CFG)
      rdata_next = pattern_cfg_reg;
    else if (reg_addr == `TTPE_ADDR_LOOP_CFG)
      rdata_next = loop_code_cfg_reg;
    else if (reg_addr == `TTPE_ADDR_LOOP_PAT)
      rdata_next = loop_code_pattern_reg;
    else if (reg_addr >= `TTPE_ADDR_CHAN_BASE && reg_addr <= `TTPE_ADDR_CHAN_LAST)
      rdata_next = chan_ctrl_mem[reg_addr[4:0]];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

  // Framing positions the generators must leave alone
  always_comb
  begin
    if (e1_mode)
      protected_bit = ts_num == 5'd0 || (cas_mode && ts_num == 5'd16);
    else
      protected_bit = frame_bit_pos;
    prbs_use = pattern_go && !(pattern_cfg_reg[`TTPE_PATT_FRAMED_BIT] && protected_bit);
    loop_use = !prbs_use && loop_code_go && !e1_mode
      && (loop_code_cfg_reg[`TTPE_LOOP_UNFRAMED_BIT] || !frame_bit_pos);
  end

  ttpe_prbs u_prbs (
    .clk(clk),
    .rst(rst),
    .adv(tx_bit_valid && prbs_use),
    .sel(pattern_cfg_reg[1:0]),
    .zlim(pattern_cfg_reg[`TTPE_PATT_ZLIM_BIT]),
    .bit_out(prbs_bit)
  );

  assign loop_len = `TTPE_LOOP_LEN_MIN + {1'b0, loop_code_cfg_reg[1:0]};

  // Overwrite and single-shot inversions on the incoming bit
  always_comb
  begin
    err_clr = 8'h00;
    a_bit_next = tx_bit;
    if (prbs_use)
    begin
      a_bit_next = prbs_bit;
      if (error_insert_reg[`TTPE_ERR_PRBS])
      begin
        a_bit_next = ~prbs_bit;
        err_clr[`TTPE_ERR_PRBS] = tx_bit_valid;
      end
    end
    else if (loop_use)
      a_bit_next = loop_code_pattern_reg[3'd7 - loop_idx_reg];
    if (frame_bit_pos && error_insert_reg[`TTPE_ERR_FRAME])
    begin
      a_bit_next = ~a_bit_next;
      err_clr[`TTPE_ERR_FRAME] = tx_bit_valid;
    end
    if (crc_bit_pos && error_insert_reg[`TTPE_ERR_CRC])
    begin
      a_bit_next = ~a_bit_next;
      err_clr[`TTPE_ERR_CRC] = tx_bit_valid;
    end
    if (mf_bit_pos && error_insert_reg[`TTPE_ERR_MF])
    begin
      a_bit_next = ~a_bit_next;
      err_clr[`TTPE_ERR_MF] = tx_bit_valid;
    end
    if (mas_first_pos && error_insert_reg[`TTPE_ERR_CAS_MF])
    begin
      a_bit_next = ~a_bit_next;
      err_clr[`TTPE_ERR_CAS_MF] = tx_bit_valid;
    end
    err_clr[`TTPE_ERR_ALIGN] = error_insert_reg[`TTPE_ERR_ALIGN];
    err_clr[`TTPE_ERR_CV] = cv_done;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      loop_idx_reg <= 3'h0;
    else if (!loop_code_go)
      loop_idx_reg <= 3'h0;
    else if (tx_bit_valid && loop_use)
      loop_idx_reg <= (loop_idx_reg + 3'h1 >= loop_len) ? 3'h0 : loop_idx_reg + 3'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_valid_reg <= 1'b0;
      a_bit_reg <= 1'b0;
      a_frame_reg <= 1'b0;
      a_ts_reg <= 5'h0;
      a_bitn_reg <= 3'h0;
    end
    else
    begin
      a_valid_reg <= tx_bit_valid;
      if (tx_bit_valid)
      begin
        a_bit_reg <= a_bit_next;
        a_frame_reg <= frame_bit_pos;
        a_ts_reg <= ts_num;
        a_bitn_reg <= bit_num;
      end
    end
  end

  // The framer shifts its alignment on this pulse; T1 always deletes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      align_shift_pulse <= 1'b0;
      slip_direction_out <= 1'b0;
    end
    else
    begin
      align_shift_pulse <= error_insert_reg[`TTPE_ERR_ALIGN];
      slip_direction_out <= e1_mode && error_insert_reg[`TTPE_ERR_SLIP_DIR];
    end
  end

  // Whole channel bytes are rewritten once the last bit has arrived
  assign byte_in = {byte_sr_reg[6:0], a_bit_reg};
  assign byte_end = a_bitn_reg == 3'd7 && !a_frame_reg && !(e1_mode && a_ts_reg == 5'd0);

  always_comb
  begin
    byte_next = byte_in;
    if (byte_end && byte_in == 8'h00)
    begin
      if (line_code_select == `TTPE_LC_UMC)
        byte_next = `TTPE_UMC_BYTE;
      else if (chan_ctrl_mem[a_ts_reg][`TTPE_CHAN_B7_BIT])
        byte_next = `TTPE_B7_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      byte_sr_reg <= 8'h00;
      frame_sr_reg <= 8'h00;
    end
    else if (a_valid_reg)
    begin
      byte_sr_reg <= byte_next;
      frame_sr_reg <= {frame_sr_reg[6:0], a_frame_reg};
    end
  end

  // Density enforcement only looks at zero runs, a simplified window
  assign c_bit = byte_sr_reg[7] || (line_code_select == `TTPE_LC_PDV && !e1_mode
    && !frame_sr_reg[7] && pdv_zero_reg == `TTPE_PDV_ZERO_MAX);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pdv_zero_reg <= 4'h0;
    else if (a_valid_reg)
      pdv_zero_reg <= c_bit ? 4'h0 : pdv_zero_reg + 4'h1;
  end

  // Substituted data feeds the CRC generator ahead of the line coder
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      subst_valid <= 1'b0;
      subst_bit <= 1'b0;
    end
    else
    begin
      subst_valid <= a_valid_reg;
      subst_bit <= a_valid_reg && c_bit;
    end
  end

  always_comb
  begin
    bip_mode = ttpe_pkg::TTPE_BIP_AMI;
    if (line_code_select == `TTPE_LC_ZCS)
      bip_mode = e1_mode ? ttpe_pkg::TTPE_BIP_HDB3 : ttpe_pkg::TTPE_BIP_B8ZS;
  end

  ttpe_bipolar_enc u_enc (
    .clk(clk),
    .rst(rst),
    .bit_valid(a_valid_reg),
    .bit_in(c_bit),
    .mode(bip_mode),
    .cv_req(error_insert_reg[`TTPE_ERR_CV]),
    .cv_done(cv_done),
    .pos_out(pos_rail_out),
    .neg_out(neg_rail_out),
    .out_valid(rail_valid)
  );
endmodule : ttpe_tx_path

// >>> tb/ttpe_line_rx.sv
// Far-end receiver model that sorts dual-rail pulses into marks and violations
`timescale 1ns/1ps
module ttpe_line_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic rail_valid,
  input wire logic pos_rail_out,
  input wire logic neg_rail_out,
  output int marks,
  output int viols,
  output int same_viols
);
  logic last_pol;
  logic last_vpol;
  // A pulse repeating the previous polarity is a violation
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      marks <= 0;
      viols <= 0;
      same_viols <= 0;
      last_pol <= 1'b0;
      last_vpol <= 1'b0;
    end
    else if (rail_valid && (pos_rail_out || neg_rail_out))
    begin
      last_pol <= pos_rail_out;
      if (pos_rail_out == last_pol)
      begin
        viols <= viols + 1;
        last_vpol <= pos_rail_out;
        if (pos_rail_out == last_vpol)
          same_viols <= same_viols + 1;
      end
      else
        marks <= marks + 1;
    end
endmodule : ttpe_line_rx

// >>> tb/ttpe_tx_path_asserts.sv
// Port-level checker for the transmit test path
`timescale 1ns/1ps
`include "ttpe_consts.svh"
module ttpe_tx_path_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_bit_valid,
  input wire logic subst_valid,
  input wire logic pos_rail_out,
  input wire logic neg_rail_out,
  input wire logic rail_valid,
  input wire logic align_shift_pulse,
  input wire logic slip_direction_out
);
  logic [7:0] fmt_reg;
  logic slip_reg;
  logic err_wr;
  assign err_wr = reg_wr && reg_addr == `TTPE_ADDR_ERR_INS;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      fmt_reg <= `TTPE_REG_RESET;
    else if (reg_wr && reg_addr == `TTPE_ADDR_FRAME_FMT)
      fmt_reg <= reg_wdata;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      slip_reg <= 1'b0;
    else if (err_wr)
      slip_reg <= reg_wdata[`TTPE_ERR_SLIP_DIR];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_fmt_read: assert property (reg_rd && reg_addr == `TTPE_ADDR_FRAME_FMT |=>
    reg_rdata == fmt_reg) else $error("frame format readback wrong");
  a_subst_lat: assert property (tx_bit_valid |-> ##2 subst_valid)
    else $error("substituted bit late");
  a_subst_cause: assert property (subst_valid |-> $past(tx_bit_valid, 2))
    else $error("substituted bit without strobe");
  a_rail_lat: assert property (tx_bit_valid |-> ##2 rail_valid)
    else $error("rail output late");
  a_rails_excl: assert property (rail_valid |-> !(pos_rail_out && neg_rail_out))
    else $error("both rails high");
  a_align_pulse: assert property (err_wr && reg_wdata[`TTPE_ERR_ALIGN] |->
    ##[1:3] align_shift_pulse) else $error("alignment shift missing");
  a_align_single: assert property (align_shift_pulse |=> !align_shift_pulse)
    else $error("alignment shift repeated");
  a_slip_t1: assert property (align_shift_pulse && !fmt_reg[`TTPE_FMT_E1_BIT] |->
    !slip_direction_out) else $error("insertion offered in T1");
  a_slip_e1: assert property (align_shift_pulse && fmt_reg[`TTPE_FMT_E1_BIT] && slip_reg |->
    slip_direction_out) else $error("slip direction lost");
  c_insert: cover property (align_shift_pulse && slip_direction_out);
  c_pos: cover property (rail_valid && pos_rail_out);
  c_neg: cover property (rail_valid && neg_rail_out);
endmodule : ttpe_tx_path_asserts
bind ttpe_tx_path ttpe_tx_path_asserts u_ttpe_tx_path_asserts (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_bit_valid(tx_bit_valid), .subst_valid(subst_valid),
  .pos_rail_out(pos_rail_out), .neg_rail_out(neg_rail_out), .rail_valid(rail_valid),
  .align_shift_pulse(align_shift_pulse), .slip_direction_out(slip_direction_out));

// >>> tb/ttpe_tx_path_tb_top.sv
// Self-checking bench for the transmit test path
`timescale 1ns/1ps
`include "ttpe_consts.svh"
module ttpe_tx_path_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_bit_valid = 1'b0;
  logic tx_bit = 1'b0;
  logic [3:0] posf = 4'h0;
  logic [2:0] bit_num = 3'h0;
  logic [4:0] ts = 5'h01;
  logic [7:0] reg_rdata;
  logic subst_valid, subst_bit, pos_rail_out, neg_rail_out, rail_valid, align_shift_pulse;
  logic slip_direction_out;
  int failures = 0;
  int check_count = 0;
  int pulses = 0;
  int marks, viols, same_viols, m0, v0, s0;
  logic [7:0] exp;
  logic q[$];
  logic [8:0] rw_addr [7] = '{9'h070, 9'h071, 9'h076, 9'h077, 9'h078, 9'h100, 9'h11F};
  logic [7:0] ebit [4] = '{8'h02, 8'h04, 8'h40, 8'h80};
  logic [7:0] fmts [4] = '{8'h00, 8'h80, 8'h00, 8'h80};
  logic [7:0] lcs [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
  int evs [4] = '{1, 2, 16, 16};
  int ems [4] = '{63, 62, 16, 16};
  always #10 clk = ~clk;
  ttpe_tx_path u_ttpe_tx_path (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit), .frame_bit_pos(posf[0]),
    .crc_bit_pos(posf[1]), .mf_bit_pos(posf[2]), .mas_first_pos(posf[3]), .ts_num(ts),
    .bit_num(bit_num), .subst_valid(subst_valid), .subst_bit(subst_bit),
    .pos_rail_out(pos_rail_out), .neg_rail_out(neg_rail_out), .rail_valid(rail_valid),
    .align_shift_pulse(align_shift_pulse), .slip_direction_out(slip_direction_out));
  ttpe_line_rx u_ttpe_line_rx (.clk(clk), .rst(rst), .rail_valid(rail_valid),
    .pos_rail_out(pos_rail_out), .neg_rail_out(neg_rail_out), .marks(marks),
    .viols(viols), .same_viols(same_viols));
  always @(posedge clk)
  begin
    if (subst_valid)
      q.push_back(subst_bit);
    if (align_shift_pulse)
      pulses++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // One strobe every four cycles; queue index k then holds bit_num k mod 8
  task automatic send(input int n, input logic b, input int k, input logic [3:0] f);
    repeat (2) @(posedge clk);
    q.delete();
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      tx_bit_valid <= 1'b1;
      tx_bit <= b;
      posf <= (i == k) ? f : 4'h0;
      bit_num <= 3'(i);
      @(posedge clk);
      tx_bit_valid <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : send
  // First 8 entries still carry the previous stream; the checks skip 16
  function automatic int ones();
    int c = 0;
    for (int i = 16; i < q.size(); i++)
      c += q[i];
    return c;
  endfunction : ones
  function automatic int zrun();
    int r = 0;
    int m = 0;
    for (int i = 16; i < q.size(); i++)
    begin
      r = q[i] ? 0 : r + 1;
      m = (r > m) ? r : m;
    end
    return m;
  endfunction : zrun
  function automatic int permis(input int p);
    int c = 0;
    for (int i = 16; i < q.size(); i++)
      c += (q[i] !== q[i - p]);
    return c;
  endfunction : permis
  function automatic int bytemis(input logic [7:0] v);
    int c = 0;
    for (int i = 16; i < q.size(); i++)
      c += (q[i] !== v[7 - i % 8]);
    return c;
  endfunction : bytemis
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`TTPE_ADDR_ERR_INS, `TTPE_REG_RESET);
    foreach (rw_addr[i])
    begin
      rd(rw_addr[i], `TTPE_REG_RESET);
      wr(rw_addr[i], 8'h5A);
      rd(rw_addr[i], 8'h5A);
      wr(rw_addr[i], 8'h00);
    end
    wr(9'h072, 8'h5A);
    rd(9'h072, 8'h00);
    wr(`TTPE_ADDR_ERR_INS, 8'hC6);
    rd(`TTPE_ADDR_ERR_INS, 8'hC6);
    exp = 8'hC6;
    for (int j = 0; j < 4; j++)
    begin
      send(64, 1'b1, 24, 4'(1 << j));
      chk(q[32], 1'b0);
      chk(q[40], 1'b1);
      exp = exp & ~ebit[j];
      rd(`TTPE_ADDR_ERR_INS, exp);
    end
    for (int j = 0; j < 4; j++)
    begin
      wr(`TTPE_ADDR_FRAME_FMT, fmts[j]);
      wr(`TTPE_ADDR_LINE_CODE, lcs[j]);
      send(32, j < 2, -1, 4'h0);
      m0 = marks;
      v0 = viols;
      s0 = same_viols;
      if (j < 2)
        wr(`TTPE_ADDR_ERR_INS, 8'h01);
      send(64, j < 2, -1, 4'h0);
      chk(viols - v0, evs[j]);
      chk(marks - m0, ems[j]);
      if (j == 3)
        chk(same_viols - s0, 0);
      rd(`TTPE_ADDR_ERR_INS, 8'h00);
    end
    wr(`TTPE_ADDR_FRAME_FMT, 8'h00);
    wr(`TTPE_ADDR_LINE_CODE, 8'h03);
    send(64, 1'b0, -1, 4'h0);
    chk(bytemis(`TTPE_UMC_BYTE), 0);
    wr(`TTPE_ADDR_LINE_CODE, 8'h00);
    wr(9'h101, 8'h01);
    send(64, 1'b0, -1, 4'h0);
    chk(bytemis(8'h02), 0);
    wr(9'h101, 8'h00);
    wr(`TTPE_ADDR_LINE_CODE, 8'h02);
    send(64, 1'b0, -1, 4'h0);
    chk(zrun(), 14);
    wr(`TTPE_ADDR_LINE_CODE, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr(`TTPE_ADDR_PATT_CFG, 8'(8'h14 | s));
      send(400, 1'b0, -1, 4'h0);
      chk(zrun() < (s < 2 ? 8 : 15), 1);
      chk(ones() > 100, 1);
    end
    // Framed E1 pattern must leave timeslot 0, and 16 under CAS, as sent
    wr(`TTPE_ADDR_FRAME_FMT, 8'h88);
    for (int t = 0; t < 2; t++)
    begin
      ts <= t ? 5'h10 : 5'h00;
      wr(`TTPE_ADDR_PATT_CFG, 8'h1B);
      send(64, 1'b0, -1, 4'h0);
      chk(ones(), 0);
    end
    ts <= 5'h01;
    wr(`TTPE_ADDR_FRAME_FMT, 8'h00);
    wr(`TTPE_ADDR_ERR_INS, 8'h20);
    send(8, 1'b0, -1, 4'h0);
    rd(`TTPE_ADDR_ERR_INS, 8'h00);
    wr(`TTPE_ADDR_PATT_CFG, 8'h00);
    send(64, 1'b0, -1, 4'h0);
    chk(ones(), 0);
    wr(`TTPE_ADDR_LOOP_PAT, 8'h80);
    for (int p = 4; p < 8; p++)
    begin
      wr(`TTPE_ADDR_LOOP_CFG, 8'(8'h0C | (p - 4)));
      send(64, 1'b0, -1, 4'h0);
      chk(permis(p), 0);
      chk(ones() > 0, 1);
    end
    wr(`TTPE_ADDR_FRAME_FMT, 8'h80);
    send(64, 1'b0, -1, 4'h0);
    chk(ones(), 0);
    wr(`TTPE_ADDR_LOOP_CFG, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      wr(`TTPE_ADDR_FRAME_FMT, m ? 8'h80 : 8'h00);
      wr(`TTPE_ADDR_ERR_INS, 8'h18);
      repeat (4) @(posedge clk);
      chk(pulses, m + 1);
      chk(slip_direction_out, m);
      rd(`TTPE_ADDR_ERR_INS, 8'h10);
    end
    close_out();
  end
endmodule : ttpe_tx_path_tb_top
